// file: logic/ebsc_pkg.sv
package ebsc_pkg;

	// ------------------------------------------------------------
	// Widths and thresholds
	// ------------------------------------------------------------
	localparam int WAIT_W = 3;
	localparam logic [WAIT_W-1:0] READY_MIN_WAIT = 3'h2;
	localparam logic [WAIT_W-1:0] WAIT_ZERO = 3'h0;
	localparam logic [WAIT_W-1:0] WAIT_STEP = 3'h1;

	// ------------------------------------------------------------
	// Pin levels
	// ------------------------------------------------------------
	localparam logic PORT_ROLE_HOST = 1'b0;
	localparam logic PORT_ROLE_EXTERNAL_MEMORY_MODE = 1'b1;
	localparam logic RW_READ = 1'b1;
	localparam logic RW_WRITE = 1'b0;
	localparam logic SEL_ON = 1'b0;
	localparam logic SEL_OFF = 1'b1;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SPACE_PROG = 2'h0,
		SPACE_DATA = 2'h1,
		SPACE_IO = 2'h2,
		SPACE_NONE = 2'h3
	} ebsc_space_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_COUNT = 2'h1,
		ST_CHECK = 2'h3,
		ST_FINISH = 2'h2
	} ebsc_state_type;

endpackage

// file: logic/ebsc_gpio_pin.sv
module ebsc_gpio_pin (
	input wire logic hostMode,
	input wire logic driveAllowed,
	input wire logic emifLevel,
	input wire logic gpioOut,
	input wire logic gpioDir,
	input wire logic timerOut,
	input wire logic timerSel,
	input wire logic pinIn,
	output logic pinOut,
	output logic pinOe,
	output logic gpioIn
);

	// ------------------------------------------------------------
	// Pin function select
	// ------------------------------------------------------------
	always_comb begin
		pinOut = emifLevel;
		pinOe = 1'b0;
		if (!hostMode) begin
			pinOut = emifLevel;
			pinOe = driveAllowed;
		end else if (timerSel) begin
			pinOut = timerOut;
			pinOe = driveAllowed;
		end else begin
			pinOut = gpioOut;
			pinOe = driveAllowed & gpioDir;
		end
	end

	// Input path stays live so software can read the pin in either mode
	assign gpioIn = pinIn;

endmodule

// file: logic/ebsc_strobe_ctrl.sv
// Contract
// - Program select low through program access
// - Data select low through data access
// - I/O select low through I/O access
// - Output disable low floats all controls except the ready pin, which host mode drives regardless
// - Memory strobe driven only in memory mode
// - Ready low stalls, resampled every cycle
// - Ready checked only with two+ waits
// - Read/write high whenever not writing
// - Read/write low during each write
// - I/O strobe only for CPU accesses
// - DMA I/O space stays internal, separate
// - Host mode: program select pin strobe 1
// - Host mode: data select pin strobe 2
// - Host mode: ready pin drives data-ready
// - Host mode: read/write pin is input
// - Host mode: I/O select is SUBSYS_B_GPIO_BIT3/timer
// - Host mode: I/O strobe is SUBSYS_A_GPIO_BIT3/timer
module ebsc_strobe_ctrl (
	input wire logic clk_sys,
	input wire logic rst_n,
	// Mode and output disable
	input wire logic portRoleSelect,
	input wire logic outputDisable_n,
	// Internal access request
	input wire logic reqValid,
	input wire ebsc_pkg::ebsc_space_type reqSpace,
	input wire logic reqWrite,
	input wire logic reqFromDma,
	input wire logic [ebsc_pkg::WAIT_W-1:0] reqWaitStates,
	output logic reqReady,
	output logic accessDone,
	output logic dmaIoAccess,
	output logic dmaIoWrite,
	output logic externalMemoryMode,
	output logic hostPortMode,
	// Program space select pin
	input wire logic programSpaceSelectIn,
	output logic programSpaceSelectOut_n,
	output logic programSpaceSelectOe,
	// Data space select pin
	input wire logic dataSpaceSelectIn,
	output logic dataSpaceSelectOut_n,
	output logic dataSpaceSelectOe,
	// I/O space select pin
	input wire logic ioSpaceSelectIn,
	output logic ioSpaceSelectOut_n,
	output logic ioSpaceSelectOe,
	// Memory strobe pin
	output logic memStrobeOut_n,
	output logic memStrobeOe,
	// I/O strobe pin
	input wire logic ioStrobeIn,
	output logic ioStrobeOut_n,
	output logic ioStrobeOe,
	// Read/write pin
	input wire logic readWriteIn,
	output logic readWriteOut,
	output logic readWriteOe,
	// Ready pin
	input wire logic readyIn,
	output logic readyOut,
	output logic readyOe,
	// Host-port side
	input wire logic hostDataReady,
	output logic hostStrobe1,
	output logic hostStrobe2,
	output logic hostReadWrite,
	// Subsystem A bit 3 function
	input wire logic subsysAGpioBit3Out,
	input wire logic subsysAGpioBit3Dir,
	input wire logic subsysATimerOut,
	input wire logic subsysATimerSel,
	output logic subsysAGpioBit3In,
	// Subsystem B bit 3 function
	input wire logic subsysBGpioBit3Out,
	input wire logic subsysBGpioBit3Dir,
	input wire logic subsysBTimerOut,
	input wire logic subsysBTimerSel,
	output logic subsysBGpioBit3In
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		ebsc_pkg::ebsc_state_type fsm;
		ebsc_pkg::ebsc_space_type space;
		logic write;
		logic useReady;
		logic [ebsc_pkg::WAIT_W-1:0] waitCnt;
		logic progSelN;
		logic dataSelN;
		logic ioSelN;
		logic memStrobeN;
		logic ioStrobeN;
		logic readWrite;
		logic done;
		logic dmaIo;
		logic dmaIoWr;
	} ebsc_regs_type;

	ebsc_regs_type q;
	ebsc_regs_type d;

	logic emifMode;
	logic driveAllowed;
	logic accessActive;
	logic strobeActive;
	logic requestLegal;
	logic reqIsDmaIo;

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	// Role pin taken as synchronous; switch it only between accesses
	assign emifMode = (portRoleSelect == ebsc_pkg::PORT_ROLE_EXTERNAL_MEMORY_MODE);
	assign driveAllowed = outputDisable_n;
	assign externalMemoryMode = emifMode;
	assign hostPortMode = !emifMode;

	// Unused space code is never taken, so no pin can glitch on it
	assign requestLegal = (reqSpace != ebsc_pkg::SPACE_NONE);

	// ------------------------------------------------------------
	// Initiator decode
	// ------------------------------------------------------------
	// DMA owns a private I/O space, so these cycles never reach a pin
	assign reqIsDmaIo = reqFromDma && (reqSpace == ebsc_pkg::SPACE_IO);

	// ------------------------------------------------------------
	// Request handshake
	// ------------------------------------------------------------
	// Busy, host mode and the spare space code all refuse
	always_comb begin
		reqReady = 1'b0;
		if (emifMode && (q.fsm == ebsc_pkg::ST_IDLE) && requestLegal) begin
			reqReady = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.done = 1'b0;
		d.dmaIo = 1'b0;
		d.dmaIoWr = 1'b0;
		unique case (q.fsm)
			ebsc_pkg::ST_IDLE: begin
				if (reqValid && reqReady) begin
					if (reqIsDmaIo) begin
						// DMA I/O never reaches the pins
						d.dmaIo = 1'b1;
						d.dmaIoWr = reqWrite;
						d.done = 1'b1;
					end else begin
						d.fsm = ebsc_pkg::ST_COUNT;
						d.space = reqSpace;
						d.write = reqWrite;
						d.waitCnt = reqWaitStates;
						d.useReady = (reqWaitStates >= ebsc_pkg::READY_MIN_WAIT);
					end
				end
			end
			ebsc_pkg::ST_COUNT: begin
				// Count reaches zero before ready is looked at
				if (q.waitCnt != ebsc_pkg::WAIT_ZERO) begin
					d.waitCnt = q.waitCnt - ebsc_pkg::WAIT_STEP;
				end else if (q.useReady) begin
					d.fsm = ebsc_pkg::ST_CHECK;
				end else begin
					d.fsm = ebsc_pkg::ST_FINISH;
				end
			end
			ebsc_pkg::ST_CHECK: begin
				// Low ready holds here one cycle and samples again
				if (readyIn) begin
					d.fsm = ebsc_pkg::ST_FINISH;
				end else begin
					d.fsm = ebsc_pkg::ST_CHECK;
				end
			end
			ebsc_pkg::ST_FINISH: begin
				// Strobe already high here, selects drop next for hold
				d.fsm = ebsc_pkg::ST_IDLE;
				d.done = 1'b1;
			end
		endcase

		// Role change mid access simply drops the cycle
		if (!emifMode) begin
			d.fsm = ebsc_pkg::ST_IDLE;
			d.done = 1'b0;
			d.dmaIo = 1'b0;
			d.dmaIoWr = 1'b0;
			d.waitCnt = ebsc_pkg::WAIT_ZERO;
			d.useReady = 1'b0;
			d.write = 1'b0;
		end

		// ------------------------------------------------------------
		// Pin levels
		// ------------------------------------------------------------
		// Pin levels follow the next state so they come from flip-flops
		accessActive = (d.fsm != ebsc_pkg::ST_IDLE);
		strobeActive = (d.fsm == ebsc_pkg::ST_COUNT) || (d.fsm == ebsc_pkg::ST_CHECK);

		d.progSelN = ebsc_pkg::SEL_OFF;
		d.dataSelN = ebsc_pkg::SEL_OFF;
		d.ioSelN = ebsc_pkg::SEL_OFF;
		d.memStrobeN = ebsc_pkg::SEL_OFF;
		d.ioStrobeN = ebsc_pkg::SEL_OFF;
		d.readWrite = ebsc_pkg::RW_READ;
		if (accessActive) begin
			unique case (d.space)
				ebsc_pkg::SPACE_PROG: begin
					d.progSelN = ebsc_pkg::SEL_ON;
					if (strobeActive) begin
						d.memStrobeN = ebsc_pkg::SEL_ON;
					end
				end
				ebsc_pkg::SPACE_DATA: begin
					d.dataSelN = ebsc_pkg::SEL_ON;
					if (strobeActive) begin
						d.memStrobeN = ebsc_pkg::SEL_ON;
					end
				end
				ebsc_pkg::SPACE_IO: begin
					d.ioSelN = ebsc_pkg::SEL_ON;
					// Only CPU cycles get here; DMA I/O was diverted
					if (strobeActive) begin
						d.ioStrobeN = ebsc_pkg::SEL_ON;
					end
				end
				default: begin
					d.progSelN = ebsc_pkg::SEL_OFF;
				end
			endcase
			if (d.write) begin
				d.readWrite = ebsc_pkg::RW_WRITE;
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			q.fsm <= ebsc_pkg::ST_IDLE;
			q.space <= ebsc_pkg::SPACE_PROG;
			q.write <= 1'b0;
			q.useReady <= 1'b0;
			q.waitCnt <= ebsc_pkg::WAIT_ZERO;
			q.progSelN <= ebsc_pkg::SEL_OFF;
			q.dataSelN <= ebsc_pkg::SEL_OFF;
			q.ioSelN <= ebsc_pkg::SEL_OFF;
			q.memStrobeN <= ebsc_pkg::SEL_OFF;
			q.ioStrobeN <= ebsc_pkg::SEL_OFF;
			q.readWrite <= ebsc_pkg::RW_READ;
			q.done <= 1'b0;
			q.dmaIo <= 1'b0;
			q.dmaIoWr <= 1'b0;
		end else begin
			q <= d;
		end
	end


	// ------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------
	assign accessDone = q.done;
	assign dmaIoAccess = q.dmaIo;
	assign dmaIoWrite = q.dmaIoWr;

	// ------------------------------------------------------------
	// Program and data select pins
	// ------------------------------------------------------------
	assign programSpaceSelectOut_n = q.progSelN;
	assign programSpaceSelectOe = emifMode & driveAllowed;
	assign hostStrobe1 = emifMode ? 1'b1 : programSpaceSelectIn;

	assign dataSpaceSelectOut_n = q.dataSelN;
	assign dataSpaceSelectOe = emifMode & driveAllowed;
	assign hostStrobe2 = emifMode ? 1'b1 : dataSpaceSelectIn;

	// ------------------------------------------------------------
	// Memory strobe and direction
	// ------------------------------------------------------------
	assign memStrobeOut_n = q.memStrobeN;
	assign memStrobeOe = emifMode & driveAllowed;

	assign readWriteOut = q.readWrite;
	assign readWriteOe = emifMode & driveAllowed;
	// Idles as read so host logic sees a benign level in memory mode
	assign hostReadWrite = emifMode ? ebsc_pkg::RW_READ : readWriteIn;

	// ------------------------------------------------------------
	// Ready pin
	// ------------------------------------------------------------
	// Turnaround is left to the role pin; no overlap guard here
	assign readyOut = hostDataReady;
	assign readyOe = !emifMode;

	// ------------------------------------------------------------
	// Shared GPIO pins
	// ------------------------------------------------------------
	// Output disable still floats these pins in host mode
	ebsc_gpio_pin ioSelectPin (
		.hostMode(!emifMode),
		.driveAllowed(driveAllowed),
		.emifLevel(q.ioSelN),
		.gpioOut(subsysBGpioBit3Out),
		.gpioDir(subsysBGpioBit3Dir),
		.timerOut(subsysBTimerOut),
		.timerSel(subsysBTimerSel),
		.pinIn(ioSpaceSelectIn),
		.pinOut(ioSpaceSelectOut_n),
		.pinOe(ioSpaceSelectOe),
		.gpioIn(subsysBGpioBit3In)
	);

	ebsc_gpio_pin ioStrobePin (
		.hostMode(!emifMode),
		.driveAllowed(driveAllowed),
		.emifLevel(q.ioStrobeN),
		.gpioOut(subsysAGpioBit3Out),
		.gpioDir(subsysAGpioBit3Dir),
		.timerOut(subsysATimerOut),
		.timerSel(subsysATimerSel),
		.pinIn(ioStrobeIn),
		.pinOut(ioStrobeOut_n),
		.pinOe(ioStrobeOe),
		.gpioIn(subsysAGpioBit3In)
	);

endmodule

// file: tb/ebsc_checker.sv
module ebsc_checker (
	input logic clk_sys,
	input logic rst_n,
	input logic outputDisable_n,
	input logic reqValid,
	input logic reqReady,
	input ebsc_pkg::ebsc_space_type reqSpace,
	input logic reqWrite,
	input logic reqFromDma,
	input logic [ebsc_pkg::WAIT_W-1:0] reqWaitStates,
	input logic accessDone,
	input logic dmaIoAccess,
	input logic hostPortMode,
	input logic programSpaceSelectIn,
	input logic programSpaceSelectOut_n,
	input logic programSpaceSelectOe,
	input logic dataSpaceSelectOut_n,
	input logic ioSpaceSelectOut_n,
	input logic memStrobeOe,
	input logic ioStrobeOut_n,
	input logic readWriteOut,
	input logic readWriteOe,
	input logic readyOut,
	input logic readyOe,
	input logic hostDataReady,
	input logic hostStrobe1
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Checks
	// ----
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence sTake;
		reqValid && reqReady;
	endsequence
	sequence sDmaIo;
		sTake ##0 (reqFromDma && reqSpace == ebsc_pkg::SPACE_IO);
	endsequence
	sequence sExt;
		sTake ##0 !(reqFromDma && reqSpace == ebsc_pkg::SPACE_IO);
	endsequence
	a_prog_sel: assert property (sTake ##0 reqSpace == ebsc_pkg::SPACE_PROG
		|=> !programSpaceSelectOut_n [*2]) else $error("program select not held");
	a_data_sel: assert property (sTake ##0 reqSpace == ebsc_pkg::SPACE_DATA
		|=> !dataSpaceSelectOut_n [*2]) else $error("data select not held");
	a_io_sel: assert property (sExt ##0 reqSpace == ebsc_pkg::SPACE_IO
		|=> !ioSpaceSelectOut_n && !ioStrobeOut_n) else $error("io select missing");
	a_dma_io: assert property (sDmaIo |=> dmaIoAccess && accessDone
		&& ioStrobeOut_n && ioSpaceSelectOut_n) else $error("dma io went outside");
	a_off_float: assert property (!outputDisable_n |->
		!(programSpaceSelectOe || memStrobeOe || readWriteOe)) else $error("pins not floated");
	a_strobe_mode: assert property (hostPortMode |-> !memStrobeOe)
		else $error("strobe driven in host mode");
	a_ready_pin: assert property (hostPortMode |-> readyOe && readyOut == hostDataReady)
		else $error("ready pin not driven");
	a_host_strobe: assert property (hostPortMode |->
		hostStrobe1 == programSpaceSelectIn && !programSpaceSelectOe) else $error("strobe1 wrong");
	a_rw_idle: assert property (programSpaceSelectOut_n && dataSpaceSelectOut_n
		&& ioSpaceSelectOut_n |-> readWriteOut) else $error("rw low while idle");
	a_write_rw: assert property (sExt ##0 reqWrite |=> !readWriteOut)
		else $error("rw high on write");
	a_short_wait: assert property (sExt ##0 reqWaitStates == 3'h1 |-> ##4 accessDone)
		else $error("ready not ignored");
endmodule

// file: tb/ebsc_mem_model.sv
module ebsc_mem_model (
	input logic clk_sys,
	input logic rst_n,
	input logic strobe_n,
	input int stall,
	output logic ready
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	always_ff @(posedge clk_sys) cnt <= (!rst_n || strobe_n) ? 0 : cnt + 1;
	// Slow device keeps ready low until done
	assign ready = cnt >= stall;
endmodule

// file: tb/ebsc_strobe_ctrl_test.sv
module ebsc_strobe_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		ebsc_pkg::ebsc_space_type sp;
		logic wr;
		logic dma;
		logic [2:0] n;
		int stall;
	} ebsc_row_type;
	logic clk_sys, rst_n, portRoleSelect, outputDisable_n, reqValid, reqWrite, reqFromDma;
	logic [2:0] reqWaitStates;
	ebsc_pkg::ebsc_space_type reqSpace;
	logic reqReady, accessDone, dmaIoAccess, dmaIoWrite, externalMemoryMode, hostPortMode;
	logic programSpaceSelectIn, programSpaceSelectOut_n, programSpaceSelectOe;
	logic dataSpaceSelectIn, dataSpaceSelectOut_n, dataSpaceSelectOe;
	logic ioSpaceSelectIn, ioSpaceSelectOut_n, ioSpaceSelectOe, memStrobeOut_n, memStrobeOe;
	logic ioStrobeIn, ioStrobeOut_n, ioStrobeOe, readWriteIn, readWriteOut, readWriteOe;
	logic readyIn, readyOut, readyOe, hostDataReady, hostStrobe1, hostStrobe2, hostReadWrite;
	logic subsysAGpioBit3Out, subsysAGpioBit3Dir, subsysATimerOut, subsysATimerSel;
	logic subsysBGpioBit3Out, subsysBGpioBit3Dir, subsysBTimerOut, subsysBTimerSel;
	logic subsysAGpioBit3In, subsysBGpioBit3In, tbPs, tbDs, tbIs, tbIo, tbRw, mdlReady;
	int n_mismatch, compares, stall;
	logic [7:0] gotBits;
	// Testbench-driven levels on the shared pins when nobody drives them
	assign programSpaceSelectIn = programSpaceSelectOe ? programSpaceSelectOut_n : tbPs;
	assign dataSpaceSelectIn = dataSpaceSelectOe ? dataSpaceSelectOut_n : tbDs;
	assign ioSpaceSelectIn = ioSpaceSelectOe ? ioSpaceSelectOut_n : tbIs;
	assign ioStrobeIn = ioStrobeOe ? ioStrobeOut_n : tbIo;
	assign readWriteIn = readWriteOe ? readWriteOut : tbRw;
	assign readyIn = readyOe ? readyOut : mdlReady;
	ebsc_strobe_ctrl u_dut (.*);
	ebsc_mem_model u_mem (.clk_sys(clk_sys), .rst_n(rst_n),
		.strobe_n(memStrobeOut_n & ioStrobeOut_n), .stall(stall), .ready(mdlReady));
	ebsc_row_type rows[7] = '{
		'{ebsc_pkg::SPACE_PROG, 1'b0, 1'b0, 3'h0, 0}, '{ebsc_pkg::SPACE_DATA, 1'b1, 1'b0, 3'h2, 5},
		'{ebsc_pkg::SPACE_IO, 1'b0, 1'b0, 3'h1, 9}, '{ebsc_pkg::SPACE_IO, 1'b1, 1'b0, 3'h3, 0},
		'{ebsc_pkg::SPACE_PROG, 1'b0, 1'b0, 3'h4, 9}, '{ebsc_pkg::SPACE_IO, 1'b1, 1'b1, 3'h0, 0},
		'{ebsc_pkg::SPACE_DATA, 1'b0, 1'b0, 3'h2, 3}};
	// ----
	// Tasks
	// ----
	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			$display("BAD %s exp %h got %h", nm, exp, got);
			n_mismatch++;
		end
	endtask
	task end_sim;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Walk done from wait states and the stall of the far side
	function automatic int expDone(ebsc_row_type r);
		int k;
		if (r.dma && r.sp == ebsc_pkg::SPACE_IO) return 1;
		if (r.n < 2) return r.n + 3;
		k = r.stall - r.n - 1;
		return r.n + 4 + (k > 0 ? k : 0);
	endfunction
	task run(input ebsc_row_type r);
		int c;
		logic seen, ms, io;
		logic [1:0] expS;
		stall = r.stall;
		reqSpace = r.sp;
		reqWrite = r.wr;
		reqFromDma = r.dma;
		reqWaitStates = r.n;
		reqValid = 1;
		@(posedge clk_sys);
		#1 reqValid = 0;
		seen = 0;
		ms = 0;
		io = 0;
		for (c = 1; c < 40; c++) begin
			seen |= (r.sp == ebsc_pkg::SPACE_PROG ? programSpaceSelectOut_n :
				r.sp == ebsc_pkg::SPACE_DATA ? dataSpaceSelectOut_n : ioSpaceSelectOut_n) === 1'b0;
			ms |= memStrobeOut_n === 1'b0;
			io |= ioStrobeOut_n === 1'b0;
			if (accessDone === 1'b1) break;
			@(posedge clk_sys);
			#1;
		end
		chk("done", 8'(expDone(r)), 8'(c));
		chk("sel", {7'h0, !r.dma}, {7'h0, seen});
		expS = {r.sp != ebsc_pkg::SPACE_IO, r.sp == ebsc_pkg::SPACE_IO && !r.dma};
		chk("strb", {6'h0, expS}, {6'h0, ms, io});
		chk("dmaw", {7'h0, r.dma && r.wr}, {7'h0, dmaIoWrite});
	endtask
	initial begin
		clk_sys = 0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		#20000;
		n_mismatch++;
		end_sim;
	end
	initial begin
		{rst_n, reqValid, reqWrite, reqFromDma, reqWaitStates, hostDataReady, stall} = '0;
		{portRoleSelect, outputDisable_n, tbPs, tbDs, tbIs, tbIo, tbRw} = '1;
		{subsysAGpioBit3Out, subsysAGpioBit3Dir, subsysATimerOut, subsysATimerSel} = '0;
		{subsysBGpioBit3Out, subsysBGpioBit3Dir, subsysBTimerOut, subsysBTimerSel} = '0;
		reqSpace = ebsc_pkg::SPACE_PROG;
		repeat (16) @(posedge clk_sys);
		#1 gotBits = {4'h0, readWriteOut, programSpaceSelectOut_n, memStrobeOut_n, !accessDone};
		chk("rst", 8'h0f, gotBits);
		$display("reset test done");
		rst_n = 1;
		foreach (rows[i]) run(rows[i]);
		$display("access table done");
		reqSpace = ebsc_pkg::SPACE_PROG;
		reqWaitStates = 3'h4;
		reqValid = 1;
		@(posedge clk_sys);
		#1 reqValid = 0;
		repeat (2) @(posedge clk_sys);
		#1 portRoleSelect = 0;
		@(posedge clk_sys);
		#1 chk("abort", 8'h02, {6'h0, programSpaceSelectOut_n, accessDone});
		portRoleSelect = 1;
		@(posedge clk_sys);
		#1 chk("resume", 8'h01, {6'h0, accessDone, reqReady});
		$display("abort test done");
		reqSpace = ebsc_pkg::SPACE_NONE;
		outputDisable_n = 0;
		@(posedge clk_sys);
		#1 chk("space3", 8'h0, {7'h0, reqReady});
		chk("off", 8'h0, {2'h0, programSpaceSelectOe, dataSpaceSelectOe, ioSpaceSelectOe,
			memStrobeOe, ioStrobeOe, readWriteOe});
		{outputDisable_n, portRoleSelect, hostDataReady, tbPs, tbDs, tbRw} = 6'b101000;
		{subsysATimerSel, subsysBTimerSel, subsysATimerOut, subsysBTimerOut} = 4'b1100;
		@(posedge clk_sys);
		#1 gotBits = {1'b0, externalMemoryMode, hostPortMode, readyIn, hostStrobe2, hostStrobe1,
			hostReadWrite, reqReady};
		chk("host", 8'h30, gotBits);
		gotBits = {4'h0, ioStrobeOe, ioStrobeOut_n, ioSpaceSelectOe, ioSpaceSelectOut_n};
		chk("tout", 8'h0a, gotBits);
		{subsysATimerSel, subsysBTimerSel, tbIo, tbIs} = 4'b0010;
		@(posedge clk_sys);
		#1 gotBits = {4'h0, ioStrobeOe, ioSpaceSelectOe, subsysAGpioBit3In, subsysBGpioBit3In};
		chk("gpio", 8'h02, gotBits);
		$display("pin modes done");
		end_sim;
	end
endmodule
bind ebsc_strobe_ctrl ebsc_checker u_chk (.*);
